//--- hw/synchronous_serial_port.sv
// synchronous serial port: master/slave frame engine, fifos, pins, interrupt
`timescale 1ns/1ns
`include "ssp_consts.svh"
module synchronous_serial_port (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic portEnable,
    input wire logic masterMode,
    input wire logic loopbackMode,
    input wire logic [1:0] slaveCount,
    input wire logic [3:0] slaveFormat,
    input wire logic [15:0] slaveWordSize,
    input wire logic [7:0] prescaleDiv,
    input wire logic [7:0] bitRateDiv,
    input wire ssp_pkg::word_t txData,
    input wire logic txValid,
    output logic txReady,
    output ssp_pkg::word_t rxData,
    output logic rxValid,
    input wire logic rxReady,
    input wire logic txIrqMask,
    input wire logic rxIrqMask,
    input wire logic overrunIrqMask,
    input wire logic overrunClear,
    output logic overrunFlag,
    output logic busy,
    output logic combinedIrq,
    input wire logic sclkIn,
    output logic sclkOut,
    output logic sclkOe,
    input wire logic [3:0] selIn,
    output logic [3:0] selOut,
    output logic [3:0] selOe,
    input wire logic serialDataIn,
    output logic serialDataOut
);
    import ssp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    function automatic size_t clampSize(input size_t sizeM1);
        clampSize = (sizeM1 < `SSP_MIN_SIZE_M1) ? `SSP_MIN_SIZE_M1 : sizeM1;
    endfunction

    function automatic word_t leftAlign(input word_t w, input size_t sizeM1);
        leftAlign = w << (`SSP_MAX_SIZE_M1 - sizeM1);
    endfunction

    function automatic word_t sizeMask(input size_t sizeM1);
        sizeMask = 16'hFFFF >> (`SSP_MAX_SIZE_M1 - sizeM1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    ssp_state_e state_reg;
    logic curFmt_reg;
    size_t curSize_reg;
    logic [1:0] slaveIdx_reg;
    logic [1:0] frameSlave_reg;
    word_t txShift_reg;
    word_t rxShift_reg;
    logic [4:0] sampled_reg;
    logic sck_reg;
    logic overrun_reg;
    logic irq_reg;

    logic sckMeta_reg;
    logic sckSync_reg;
    logic sckPrev_reg;
    logic selMeta_reg;
    logic selSync_reg;
    logic dinMeta_reg;
    logic dinSync_reg;

    word_t txFifoData;
    logic txFifoValid;
    logic txPop;
    logic rxFifoReady;
    logic rxPush;
    word_t rxWord;

    logic divRun;
    logic edgeTick;
    logic sckRun;
    logic mRise;
    logic mFall;
    logic sRise;
    logic sFall;
    logic riseEv;
    logic fallEv;
    logic sampleEv;
    logic shiftEv;
    logic rxBit;
    logic frameStart;
    logic frameDone;
    logic slaveAbort;
    logic loadFmt;
    size_t loadSize;
    logic [1:0] loadSlave;

    ////////////////////////////////////////////////////////////////////////////////
    // buffering

    sync_fifo #(
        .WIDTH(`SSP_WORD_W),
        .DEPTH(`SSP_FIFO_DEPTH)
    ) txFifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .inData(txData),
        .inValid(txValid),
        .inReady(txReady),
        .outData(txFifoData),
        .outValid(txFifoValid),
        .outReady(txPop)
    );

    sync_fifo #(
        .WIDTH(`SSP_WORD_W),
        .DEPTH(`SSP_FIFO_DEPTH)
    ) rxFifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .inData(rxWord),
        .inValid(rxPush),
        .inReady(rxFifoReady),
        .outData(rxData),
        .outValid(rxValid),
        .outReady(rxReady)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // serial clock generation, master only

    // unit rate and serial edges are enables on sys_clk, not separate clocks
    assign divRun = portEnable & masterMode & (state_reg != ST_IDLE);

    clock_divider divider (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .run(divRun),
        .prescaleDiv(prescaleDiv),
        .bitRateDiv(bitRateDiv),
        .unitTick(),
        .edgeTick(edgeTick)
    );

    // frame-sync format toggles the clock through the sync period too
    assign sckRun = (state_reg == ST_SHIFT) |
                    ((state_reg == ST_SETUP) & (curFmt_reg == `SSP_FMT_SSI)) |
                    ((state_reg == ST_GAP) & sck_reg);
    assign mRise = masterMode & edgeTick & sckRun & ~sck_reg;
    assign mFall = masterMode & edgeTick & sckRun & sck_reg;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sck_reg <= 1'b0;
        end else if (mRise | mFall) begin
            sck_reg <= ~sck_reg;
        end else if (state_reg == ST_IDLE) begin
            sck_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, slave side clock and select, and data input

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sckMeta_reg <= 1'b0;
            sckSync_reg <= 1'b0;
            sckPrev_reg <= 1'b0;
            selMeta_reg <= 1'b1;
            selSync_reg <= 1'b1;
            dinMeta_reg <= 1'b0;
            dinSync_reg <= 1'b0;
        end else begin
            sckMeta_reg <= sclkIn;
            sckSync_reg <= sckMeta_reg;
            sckPrev_reg <= sckSync_reg;
            selMeta_reg <= selIn[0];
            selSync_reg <= selMeta_reg;
            dinMeta_reg <= serialDataIn;
            dinSync_reg <= dinMeta_reg;
        end
    end

    // edge detection after sync needs sys_clk well above the serial clock
    assign sRise = ~masterMode & sckSync_reg & ~sckPrev_reg;
    assign sFall = ~masterMode & ~sckSync_reg & sckPrev_reg;
    assign riseEv = mRise | sRise;
    assign fallEv = mFall | sFall;

    // chip-select format samples on rise, frame-sync format on fall
    assign sampleEv = (curFmt_reg == `SSP_FMT_SPI) ? riseEv : fallEv;
    assign shiftEv = (curFmt_reg == `SSP_FMT_SPI) ? fallEv : riseEv;
    assign rxBit = loopbackMode ? txShift_reg[15] : dinSync_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // frame engine

    assign loadSlave = masterMode ? slaveIdx_reg : 2'h0;
    assign loadFmt = slaveFormat[loadSlave];
    assign loadSize = clampSize(slaveWordSize[4*loadSlave +: 4]);

    always_comb begin
        frameStart = 1'b0;
        if (portEnable && state_reg == ST_IDLE) begin
            if (masterMode) begin
                frameStart = txFifoValid;
            end else if (loadFmt == `SSP_FMT_SPI) begin
                frameStart = ~selSync_reg;
            end else begin
                frameStart = sFall & selSync_reg;
            end
        end
    end

    // an idle slave with nothing queued answers with zeros
    assign txPop = frameStart & txFifoValid;
    assign slaveAbort = ~masterMode & (curFmt_reg == `SSP_FMT_SPI) & selSync_reg;
    assign frameDone = (state_reg == ST_SHIFT) & shiftEv & ~slaveAbort &
                       (sampled_reg == 5'(curSize_reg) + 5'h01);
    assign rxWord = rxShift_reg & sizeMask(curSize_reg);
    assign rxPush = frameDone & rxFifoReady;

    always_ff @(posedge sys_clk) begin
        if (sys_rst || !portEnable) begin
            state_reg <= ST_IDLE;
            curFmt_reg <= `SSP_FMT_SPI;
            curSize_reg <= `SSP_MIN_SIZE_M1;
            frameSlave_reg <= `SSP_SLAVE_RST;
            txShift_reg <= `SSP_WORD_RST;
            rxShift_reg <= `SSP_WORD_RST;
            sampled_reg <= `SSP_BITCNT_RST;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (frameStart) begin
                        curFmt_reg <= loadFmt;
                        curSize_reg <= loadSize;
                        frameSlave_reg <= loadSlave;
                        txShift_reg <= leftAlign(txFifoValid ? txFifoData : `SSP_WORD_RST,
                                                 loadSize);
                        rxShift_reg <= `SSP_WORD_RST;
                        sampled_reg <= `SSP_BITCNT_RST;
                        state_reg <= masterMode ? ST_SETUP : ST_SHIFT;
                    end
                end
                ST_SETUP: begin
                    // chip-select waits a half period, frame-sync a whole clock
                    if (edgeTick && (curFmt_reg == `SSP_FMT_SPI || sck_reg)) begin
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (slaveAbort) begin
                        state_reg <= ST_IDLE;
                    end else if (sampleEv) begin
                        rxShift_reg <= {rxShift_reg[14:0], rxBit};
                        sampled_reg <= sampled_reg + 5'h01;
                    end else if (shiftEv) begin
                        if (frameDone) begin
                            txShift_reg <= `SSP_WORD_RST;
                            state_reg <= masterMode ? ST_GAP : ST_IDLE;
                        end else if (sampled_reg != `SSP_BITCNT_RST) begin
                            txShift_reg <= {txShift_reg[14:0], 1'b0};
                        end
                    end
                end
                ST_GAP: begin
                    if (edgeTick && !sck_reg) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // next slave in the sequence once a word has finished
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !masterMode) begin
            slaveIdx_reg <= `SSP_SLAVE_RST;
        end else if (state_reg == ST_GAP && edgeTick && !sck_reg) begin
            if (slaveIdx_reg >= slaveCount) begin
                slaveIdx_reg <= `SSP_SLAVE_RST;
            end else begin
                slaveIdx_reg <= slaveIdx_reg + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pins

    always_comb begin
        for (int i = 0; i < `SSP_SLAVES; i++) begin
            if (slaveFormat[i] == `SSP_FMT_SPI) begin
                selOut[i] = ~(masterMode && frameSlave_reg == 2'(i) &&
                              (state_reg == ST_SETUP || state_reg == ST_SHIFT));
            end else begin
                selOut[i] = masterMode && frameSlave_reg == 2'(i) &&
                            state_reg == ST_SETUP;
            end
        end
    end

    assign selOe = masterMode ? 4'hF : 4'h0;
    assign sclkOe = masterMode;
    assign sclkOut = sck_reg;
    assign serialDataOut = txShift_reg[15];
    assign busy = state_reg != ST_IDLE;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt sources

    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            overrun_reg <= 1'b0;
        end else if (frameDone && !rxFifoReady) begin
            overrun_reg <= 1'b1;
        end else if (overrunClear) begin
            overrun_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (~txFifoValid & ~txIrqMask) |
                       (rxValid & ~rxIrqMask) |
                       (overrun_reg & ~overrunIrqMask);
        end
    end

    assign overrunFlag = overrun_reg;
    assign combinedIrq = irq_reg;
endmodule

//--- hw/ssp_consts.svh
// constants of the synchronous serial port: sizes, encodings, reset values
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

`define SSP_WORD_W 16
`define SSP_FIFO_DEPTH 32
`define SSP_SLAVES 4
`define SSP_FMT_SPI 1'b0
`define SSP_FMT_SSI 1'b1
`define SSP_MIN_SIZE_M1 4'h3
`define SSP_MAX_SIZE_M1 4'hF
`define SSP_DIV_RST 8'h00
`define SSP_BITCNT_RST 5'h00
`define SSP_WORD_RST 16'h0000
`define SSP_SLAVE_RST 2'h0

`endif

//--- hw/ssp_pkg.sv
// types shared by the synchronous serial port modules
`include "ssp_consts.svh"
package ssp_pkg;
    typedef logic [`SSP_WORD_W-1:0] word_t;
    typedef logic [3:0] size_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_SHIFT,
        ST_GAP
    } ssp_state_e;
endpackage

//--- hw/sync_fifo.sv
// single-clock fifo with valid/ready on both sides
`timescale 1ns/1ns
module sync_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign inReady = count_reg != (AW+1)'(DEPTH);
    assign outValid = count_reg != '0;
    assign outData = mem[rdPtr_reg];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count_reg <= '0;
        end else if (push & ~pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop & ~push) begin
            count_reg <= count_reg - 1'b1;
        end
    end
endmodule

//--- hw/clock_divider.sv
// prescaler and bit-rate divider producing serial clock edge enables
`timescale 1ns/1ns
`include "ssp_consts.svh"
module clock_divider (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [7:0] prescaleDiv,
    input wire logic [7:0] bitRateDiv,
    output logic unitTick,
    output logic edgeTick
);
    logic [7:0] preCnt_reg;
    logic [7:0] rateCnt_reg;

    // stopped counters restart aligned so the first edge is a full half period away
    assign unitTick = run & (preCnt_reg == prescaleDiv);
    assign edgeTick = unitTick & (rateCnt_reg == bitRateDiv);

    always_ff @(posedge sys_clk) begin
        if (sys_rst | ~run) begin
            preCnt_reg <= `SSP_DIV_RST;
        end else if (unitTick) begin
            preCnt_reg <= `SSP_DIV_RST;
        end else begin
            preCnt_reg <= preCnt_reg + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst | ~run) begin
            rateCnt_reg <= `SSP_DIV_RST;
        end else if (edgeTick) begin
            rateCnt_reg <= `SSP_DIV_RST;
        end else if (unitTick) begin
            rateCnt_reg <= rateCnt_reg + 8'h01;
        end
    end
endmodule

//--- test/ssp_assertions.sv
// concurrent checks on the serial port's pins, flags and interrupt
`timescale 1ns/1ns
module ssp_assertions (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic masterMode,
    input wire logic [3:0] slaveFormat,
    input wire logic rxValid,
    input wire logic txIrqMask,
    input wire logic rxIrqMask,
    input wire logic overrunIrqMask,
    input wire logic overrunClear,
    input wire logic overrunFlag,
    input wire logic busy,
    input wire logic combinedIrq,
    input wire logic sclkOut,
    input wire logic sclkOe,
    input wire logic [3:0] selIn,
    input wire logic [3:0] selOut,
    input wire logic [3:0] selOe
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // format must be steady, else a format switch looks like a select edge
    sequence s_selFall;
        masterMode && !slaveFormat[0] && $stable(slaveFormat[0]) && $fell(selOut[0]);
    endsequence
    sequence s_selRise;
        masterMode && !slaveFormat[0] && $stable(slaveFormat[0]) && $rose(selOut[0]);
    endsequence
    property p_pinDir;
        sclkOe == masterMode && selOe == {4{masterMode}};
    endproperty
    property p_spiIdle;
        masterMode && !slaveFormat[0] && !busy |-> selOut[0];
    endproperty
    property p_ssiIdle;
        masterMode && slaveFormat[0] && !busy |-> !selOut[0];
    endproperty
    property p_setup;
        s_selFall |-> busy && !sclkOut;
    endproperty
    property p_frameEnd;
        s_selRise |-> busy && !sclkOut ##[1:600] !busy;
    endproperty
    property p_idleClk;
        masterMode && !busy |-> !sclkOut;
    endproperty
    property p_irqRx;
        rxValid && !rxIrqMask |=> combinedIrq;
    endproperty
    property p_irqMask;
        txIrqMask && rxIrqMask && overrunIrqMask |=> !combinedIrq;
    endproperty
    property p_ovSticky;
        overrunFlag && !overrunClear |=> overrunFlag;
    endproperty
    property p_ovCause;
        $rose(overrunFlag) |-> $past(rxValid);
    endproperty
    property p_slaveSel;
        (!masterMode && !slaveFormat[0] && selIn[0]) [*5] |-> !busy;
    endproperty
    a_pinDir: assert property (p_pinDir) else $error("pin direction wrong");
    a_spiIdle: assert property (p_spiIdle) else $error("select low while idle");
    a_ssiIdle: assert property (p_ssiIdle) else $error("sync high while idle");
    a_setup: assert property (p_setup) else $error("bad frame start");
    a_frameEnd: assert property (p_frameEnd) else $error("bad frame end");
    a_idleClk: assert property (p_idleClk) else $error("clock high while idle");
    a_irqRx: assert property (p_irqRx) else $error("rx irq missing");
    a_irqMask: assert property (p_irqMask) else $error("masked irq seen");
    a_ovSticky: assert property (p_ovSticky) else $error("overrun lost");
    a_ovCause: assert property (p_ovCause) else $error("overrun while empty");
    a_slaveSel: assert property (p_slaveSel) else $error("busy without select");
endmodule

bind synchronous_serial_port ssp_assertions ssp_assertions_i (
    .sys_clk, .sys_rst, .masterMode, .slaveFormat, .rxValid, .txIrqMask, .rxIrqMask,
    .overrunIrqMask, .overrunClear, .overrunFlag, .busy, .combinedIrq, .sclkOut,
    .sclkOe, .selIn, .selOut, .selOe
);

//--- test/spi_peripheral_model.sv
// behavioural serial peripheral on the far side of the master port
`timescale 1ns/1ns
module spi_peripheral_model (
    input wire logic sclk,
    input wire logic [3:0] sel,
    input wire logic sdo,
    input wire logic [15:0] reply,
    output logic sdi,
    output logic [15:0] got,
    output logic [1:0] lastSlave
);
    logic [15:0] sh;
    logic wasOff;
    initial begin
        sdi = 1'b0;
        got = 16'h0000;
        sh = 16'h0000;
        lastSlave = 2'h0;
        wasOff = 1'b1;
    end
    always @(sel) begin
        // released line flips so a stale bit is never read as data
        if (sel == 4'hF) begin
            sdi = ~sdi;
        end else if (wasOff) begin
            sh = reply;
            sdi = reply[15];
            got = 16'h0000;
            lastSlave = !sel[0] ? 2'h0 : !sel[1] ? 2'h1 : !sel[2] ? 2'h2 : 2'h3;
        end
        wasOff = (sel == 4'hF);
    end
    always @(posedge sclk) begin
        if (sel != 4'hF) got = {got[14:0], sdo};
    end
    always @(negedge sclk) begin
        if (sel != 4'hF) begin
            sh = sh << 1;
            sdi = sh[15];
        end
    end
endmodule

//--- test/synchronous_serial_port_tb.sv
// self-checking bench of the synchronous serial port
`timescale 1ns/1ns
module synchronous_serial_port_tb;
    import ssp_pkg::*;
    logic sys_clk, sys_rst, portEnable, masterMode, loopbackMode, txValid, rxReady;
    logic txIrqMask, rxIrqMask, overrunIrqMask, overrunClear, sclkIn, tbSdi, syncSeen;
    logic txReady, rxValid, overrunFlag, busy, combinedIrq, sclkOut, sclkOe, serialDataOut;
    logic modelSdi;
    logic [1:0] slaveCount, lastSlave;
    logic [3:0] slaveFormat, selIn, selOut, selOe;
    logic [7:0] prescaleDiv, bitRateDiv;
    logic [15:0] slaveWordSize, reply, cap;
    word_t txData, rxData, got;
    int errors, cmpCount, hiRun, lastRun;

    synchronous_serial_port synchronous_serial_port_i (
        .sys_clk, .sys_rst, .portEnable, .masterMode, .loopbackMode, .slaveCount,
        .slaveFormat, .slaveWordSize, .prescaleDiv, .bitRateDiv, .txData, .txValid,
        .txReady, .rxData, .rxValid, .rxReady, .txIrqMask, .rxIrqMask, .overrunIrqMask,
        .overrunClear, .overrunFlag, .busy, .combinedIrq, .sclkIn, .sclkOut, .sclkOe,
        .selIn, .selOut, .selOe, .serialDataIn(masterMode ? modelSdi : tbSdi), .serialDataOut
    );
    spi_peripheral_model spi_peripheral_model_i (
        .sclk(sclkOut), .sel(selOut), .sdo(serialDataOut), .reply, .sdi(modelSdi), .got,
        .lastSlave
    );
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (slaveFormat[0] && selOut[0] === 1'b1) syncSeen <= 1'b1;
        if (sclkOut === 1'b1) hiRun <= hiRun + 1;
        else if (hiRun != 0) begin
            lastRun <= hiRun;
            hiRun <= 0;
        end
    end
    always @(posedge sclkIn) begin
        if (!masterMode) cap <= {cap[14:0], serialDataOut};
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", cmpCount, errors);
        if (errors == 0 && cmpCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic hang;
        errors++;
        $display("wrong value at %0t: wait ran out", $time);
        close_out();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic push(input word_t w);
        int k;
        txData <= w;
        txValid <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (txReady !== 1'b1 && k < 4000);
        if (k >= 4000) hang();
        txValid <= 1'b0;
    endtask
    task automatic pop(input word_t e);
        int k;
        rxReady <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (rxValid !== 1'b1 && k < 4000);
        if (k >= 4000) hang();
        chk(rxData, e);
        rxReady <= 1'b0;
    endtask
    task automatic idle;
        int k;
        for (k = 0; k < 4000 && busy !== 1'b0; k++) @(posedge sys_clk);
        if (k >= 4000) hang();
        tick(2);
    endtask
    ////////////////////////////////////////
    task automatic t_loop;
        int sz[4] = '{0, 3, 9, 15};
        int m;
        loopbackMode <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            slaveWordSize <= 16'(sz[i]);
            tick(1);
            push(16'hB5A7);
            m = (1 << ((sz[i] < 3 ? 3 : sz[i]) + 1)) - 1;
            pop(16'hB5A7 & 16'(m));
            idle();
        end
        chk(16'(lastRun), 16'h0008);
        $display("test loopback sizes done");
    endtask
    task automatic t_ssi;
        slaveFormat <= 4'hF;
        slaveWordSize <= 16'h0007;
        syncSeen <= 1'b0;
        tick(2);
        chk(selOut[0], 1'b0);
        push(16'h125A);
        pop(16'h005A);
        chk(syncSeen, 1'b1);
        idle();
        slaveFormat <= 4'h0;
        $display("test frame sync done");
    endtask
    task automatic t_model;
        int nb[4] = '{16, 8, 4, 16};
        int m;
        loopbackMode <= 1'b0;
        rxIrqMask <= 1'b0;
        slaveCount <= 2'h3;
        slaveWordSize <= 16'hF37F;
        reply <= 16'hC3A5;
        tick(2);
        for (int i = 0; i < 4; i++) begin
            push(16'h9A60 + 16'(i));
            pop(16'hC3A5 >> (16 - nb[i]));
            m = (1 << nb[i]) - 1;
            chk(got & 16'(m), (16'h9A60 + 16'(i)) & 16'(m));
            chk(16'(lastSlave), 16'(i));
            idle();
        end
        slaveCount <= 2'h0;
        $display("test four slaves done");
    endtask
    task automatic t_fill;
        portEnable <= 1'b0;
        loopbackMode <= 1'b1;
        slaveWordSize <= 16'h0003;
        txIrqMask <= 1'b1;
        rxIrqMask <= 1'b1;
        txValid <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            txData <= 16'(i);
            @(posedge sys_clk);
            chk(txReady, 1'b1);
        end
        txValid <= 1'b0;
        tick(1);
        chk(txReady, 1'b0);
        portEnable <= 1'b1;
        push(16'h000C);
        for (int i = 0; i < 9000 && overrunFlag !== 1'b1; i++) @(posedge sys_clk);
        chk(overrunFlag, 1'b1);
        if (overrunFlag !== 1'b1) hang();
        tick(2);
        chk(combinedIrq, 1'b1);
        overrunIrqMask <= 1'b1;
        tick(2);
        chk(combinedIrq, 1'b0);
        idle();
        rxReady <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            @(posedge sys_clk);
            chk(rxData, 16'(i & 15));
        end
        rxReady <= 1'b0;
        overrunClear <= 1'b1;
        tick(1);
        overrunClear <= 1'b0;
        txIrqMask <= 1'b0;
        tick(3);
        chk(rxValid, 1'b0);
        chk(overrunFlag, 1'b0);
        chk(combinedIrq, 1'b1);
        $display("test fifo limits done");
    endtask
    task automatic t_slave;
        logic [7:0] d;
        d = 8'h6D;
        masterMode <= 1'b0;
        loopbackMode <= 1'b0;
        txIrqMask <= 1'b1;
        slaveWordSize <= 16'h0007;
        tick(10);
        chk(sclkOe, 1'b0);
        chk(selOe, 4'h0);
        chk(busy, 1'b0);
        push(16'h00B4);
        selIn <= 4'h0;
        // eight system clocks high and sixteen low per bit keeps the unit rate ahead
        for (int k = 7; k >= 0; k--) begin
            tick(8);
            tbSdi <= d[k];
            tick(8);
            sclkIn <= 1'b1;
            tick(8);
            sclkIn <= 1'b0;
        end
        tick(8);
        selIn <= 4'h1;
        pop(16'h006D);
        chk(cap[7:0], 8'hB4);
        // frame-sync slave: sync high across one fall, data changes on rise
        slaveFormat <= 4'h1;
        push(16'h00C9);
        tick(8);
        sclkIn <= 1'b1;
        tick(8);
        sclkIn <= 1'b0;
        tick(8);
        selIn <= 4'h0;
        for (int k = 7; k >= 0; k--) begin
            tick(8);
            sclkIn <= 1'b1;
            tbSdi <= d[k];
            tick(8);
            sclkIn <= 1'b0;
        end
        // one more rise closes the word
        tick(8);
        sclkIn <= 1'b1;
        tick(8);
        sclkIn <= 1'b0;
        pop(16'h006D);
        chk(cap[7:0], 8'hC9);
        $display("test slave frame done");
    endtask
    ////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        portEnable = 1'b1;
        masterMode = 1'b1;
        loopbackMode = 1'b0;
        slaveCount = 2'h0;
        slaveFormat = 4'h0;
        slaveWordSize = 16'h0007;
        prescaleDiv = 8'h01;
        bitRateDiv = 8'h03;
        txData = 16'h0000;
        txValid = 1'b0;
        rxReady = 1'b0;
        txIrqMask = 1'b1;
        rxIrqMask = 1'b1;
        overrunIrqMask = 1'b0;
        overrunClear = 1'b0;
        sclkIn = 1'b0;
        selIn = 4'h1;
        tbSdi = 1'b0;
        reply = 16'h0000;
        syncSeen = 1'b0;
        tick(10);
        sys_rst <= 1'b0;
        tick(2);
        chk(sclkOut, 1'b0);
        chk(selOut, 4'hF);
        chk(selOe, 4'hF);
        chk(txReady, 1'b1);
        chk(combinedIrq, 1'b0);
        t_loop();
        t_ssi();
        t_model();
        t_fill();
        t_slave();
        close_out();
    end
endmodule
